// [testbench.sv]
// Self-checking bench for the touch key top
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0;
  logic nrst = 1'b0;
  logic recal_n = 1'b1;
  logic strap = 1'b1;
  logic sync_en = 1'b0;
  logic [7:0] lag = 8'h02;
  logic [63:0] sig = {4{16'h03e8}};
  logic acq_valid, sync_ss, ss_out, oe_n, burst, fast;
  logic [63:0] raw;
  logic [3:0] keys;
  int fails = 0;
  int n_tests = 0;
  int cyc = 0;
  int nb;
  always #12.5 clk_in = ~clk_in;
  tks_fe_model fe (.clk_in(clk_in), .burst_req_in(burst), .sig_in(sig),
    .sync_en_in(sync_en), .lag_in(lag), .acq_valid_out(acq_valid),
    .acq_raw_out(raw), .sync_ss_out(sync_ss));
  tks_top #(.SLOW_ACQ(100), .FAST_ACQ(20)) uut (.clk_in(clk_in), .nrst_in(nrst),
    .recal_reset_n_in(recal_n), .strap_option_a_in(strap), .acq_valid_in(acq_valid),
    .acq_raw_in(raw), .sync_ss_in(sync_ss), .sync_ss_out(ss_out),
    .sync_ss_oe_n_out(oe_n), .burst_req_out(burst), .fast_mode_out(fast),
    .key_output_1_out(keys[0]), .key_output_2_out(keys[1]),
    .key_output_3_out(keys[2]), .key_output_4_out(keys[3]));
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic acqs(input int n);
    repeat (n) @(posedge acq_valid);
    repeat (6) @(negedge clk_in);
  endtask : acqs
  task automatic put(input int ch, input logic [15:0] v);
    sig[ch*16 +: 16] = v;
  endtask : put
  task automatic t_thresh;
    put(0, 16'h03f4);
    acqs(5);
    check(keys, 4'h0);
    acqs(1);
    check(keys, 4'h1);
    acqs(14);
    check(keys, 4'h1);
    put(0, 16'h03f2);
    acqs(3);
    check(keys, 4'h1);
    put(0, 16'h03f1);
    acqs(1);
    check(keys, 4'h0);
    put(0, 16'h03e8);
  endtask : t_thresh
  task automatic t_integ;
    put(1, 16'h03fc);
    acqs(5);
    put(1, 16'h03e8);
    acqs(1);
    put(1, 16'h03fc);
    acqs(5);
    check(keys, 4'h0);
    acqs(1);
    check(keys, 4'h2);
    put(1, 16'h03e8);
    acqs(1);
    check(keys, 4'h0);
  endtask : t_integ
  task automatic t_drift;
    put(2, 16'h03de);
    put(3, 16'h03f3);
    acqs(36);
    put(2, 16'h03ea);
    put(3, 16'h03f8);
    acqs(6);
    check(keys, 4'hc);
    put(2, 16'h03d4);
    put(3, 16'h03d4);
    acqs(1);
    check(keys, 4'h0);
  endtask : t_drift
  task automatic t_recal;
    recal_n = 1'b0;
    repeat (400) @(negedge clk_in);
    recal_n = 1'b1;
    sig = {16'h05dc, 16'h05dc, 16'hfff0, 16'h05dc};
    acqs(2);
    put(0, 16'h05e7);
    put(1, 16'hfffc);
    acqs(6);
    check(keys, 4'h2);
    sig = {4{16'h05dc}};
    acqs(1);
  endtask : t_recal
  task automatic t_sync;
    sync_en = 1'b1;
    lag = 8'h0a;
    nb = 0;
    repeat (740) begin
      @(negedge clk_in);
      nb += int'(burst);
    end
    check({3'h0, nb <= 11}, 4'h1);
    check({3'h0, nb >= 9}, 4'h1);
    sync_en = 1'b0;
    lag = 8'h02;
  endtask : t_sync
  task automatic t_fast;
    nrst = 1'b0;
    strap = 1'b0;
    sync_en = 1'b1;
    repeat (3) @(negedge clk_in);
    nrst = 1'b1;
    acqs(2);
    check({3'h0, fast}, 4'h1);
    check({3'h0, oe_n}, 4'h0);
    nb = 0;
    repeat (200) begin
      @(negedge clk_in);
      nb += int'(ss_out);
    end
    check({3'h0, nb > 0 && nb < 200}, 4'h1);
    put(3, 16'h05e8);
    acqs(6);
    check(keys, 4'h8);
  endtask : t_fast
  // Cuts a hang short
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 30000) begin
      fails++;
      give_verdict;
    end
  end
  initial begin
    repeat (2) @(negedge clk_in);
    nrst = 1'b1;
    acqs(2);
    t_thresh;
    t_integ;
    t_drift;
    t_recal;
    t_sync;
    t_fast;
    give_verdict;
  end
endmodule : testbench
`default_nettype wire

// [tks_ch_if.sv]
// Interface carrying per-channel acquisition and results to a channel tracker
`default_nettype none
interface tks_ch_if;
  logic acq_stb;
  logic cal;
  logic drift_up_stb;
  logic drift_dn_stb;
  logic [15:0] raw;
  logic detect;
  logic [15:0] reference;
  modport ctl (output acq_stb, output cal, output drift_up_stb, output drift_dn_stb,
    output raw, input detect, input reference);
  modport ch (input acq_stb, input cal, input drift_up_stb, input drift_dn_stb,
    input raw, output detect, output reference);
endinterface : tks_ch_if
`default_nettype wire

// [tks_channel.sv]
// One sensing channel: reference tracking, threshold, hysteresis, integrator
`default_nettype none
module tks_channel
  import tks_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Channel link
  tks_ch_if.ch chl
);
  logic [15:0] ref_r, ref_nxt;
  logic [2:0] integ_r, integ_nxt;
  logic det_r, det_nxt;
  logic [15:0] delta;
  logic above;
  logic hit;

  always_comb begin
    delta = (chl.raw > ref_r) ? 16'(chl.raw - ref_r) : 16'h0000;
    above = delta >= THRESH_CNT;
    hit = det_r ? (delta >= 16'(THRESH_CNT - HYST_CNT)) : above;
    ref_nxt = ref_r;
    integ_nxt = integ_r;
    det_nxt = det_r;
    if (chl.cal) begin
      ref_nxt = chl.raw;
      integ_nxt = 3'h0;
      det_nxt = 1'b0;
    end else if (chl.acq_stb) begin
      if (hit) begin
        if (integ_r < INTEG_LIMIT) begin
          integ_nxt = 3'(integ_r + 3'h1);
        end
        if (3'(integ_r + 3'h1) >= INTEG_LIMIT) begin
          det_nxt = 1'b1;
        end
      end else begin
        integ_nxt = 3'h0;
        det_nxt = 1'b0;
      end
    end
    // Reference frozen while detecting
    // A detecting acquisition must not drag the reference toward the touch
    if (!chl.cal && !det_r && integ_r == 3'h0 && !hit) begin
      if (chl.drift_dn_stb && chl.raw < ref_r) begin
        ref_nxt = 16'(ref_r - 16'h0001);
      end else if (chl.drift_up_stb && chl.raw > ref_r) begin
        ref_nxt = 16'(ref_r + 16'h0001);
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ref_r <= 16'h0000;
      integ_r <= 3'h0;
      det_r <= 1'b0;
    end else begin
      ref_r <= ref_nxt;
      integ_r <= integ_nxt;
      det_r <= det_nxt;
    end
  end

  assign chl.detect = det_r;
  assign chl.reference = ref_r;
endmodule : tks_channel
`default_nettype wire

// [tks_fe_model.sv]
// Acquisition front end and sync source model
`default_nettype none
module tks_fe_model (
  // Clock and burst request
  input wire logic clk_in,
  input wire logic burst_req_in,
  // Bench controls
  input wire logic [63:0] sig_in,
  input wire logic sync_en_in,
  input wire logic [7:0] lag_in,
  // Device side
  output logic acq_valid_out,
  output logic [63:0] acq_raw_out,
  output logic sync_ss_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned cnt = 0;
  int unsigned hold = 0;
  int unsigned sc = 0;
  logic req_q = 1'b0;
  initial begin
    acq_valid_out = 1'b0;
    acq_raw_out = '1;
    sync_ss_out = 1'b0;
  end
  always @(negedge clk_in) begin
    req_q <= burst_req_in;
    sc <= (sc == 73) ? 0 : sc + 1;
    sync_ss_out <= sync_en_in && (sc < 4);
    acq_valid_out <= (cnt == 1);
    if (burst_req_in && !req_q) cnt <= lag_in + 1;
    else if (cnt != 0) cnt <= cnt - 1;
    // Data is held a few cycles past valid, then scrambled
    if (cnt == 1) begin
      acq_raw_out <= sig_in;
      hold <= 6;
    end else if (hold != 0) begin
      hold <= hold - 1;
      if (hold == 1) acq_raw_out <= ~acq_raw_out;
    end
  end
endmodule : tks_fe_model
`default_nettype wire

// [tks_pkg.sv]
// Package of constants and types for the touch key signal processing block
`default_nettype none
package tks_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned NUM_CH = 4;
  localparam int unsigned DW = 16;
  localparam logic [15:0] THRESH_CNT = 16'h000c;
  localparam logic [15:0] HYST_CNT = 16'h0002;
  localparam logic [2:0] INTEG_LIMIT = 3'h6;
  localparam int unsigned SLOW_RESP_MS = 100;
  localparam int unsigned FAST_RESP_MS = 40;
  localparam int unsigned SLEEP_MS = 90;
  localparam int unsigned SYNC_ASSUMED_MS = 18;
  localparam int unsigned RESET_MIN_US = 10;
  localparam int unsigned SLOW_ACQ_CYC = (CLK_HZ / 1000) * SLEEP_MS;
  localparam int unsigned FAST_ACQ_CYC = (CLK_HZ / 1000) * FAST_RESP_MS / INTEG_LIMIT;
  localparam int unsigned RESET_MIN_CYC = (CLK_HZ / 1000000) * RESET_MIN_US;
  localparam logic [7:0] DRIFT_DOWN_STEPS = 8'h02;
  localparam logic [7:0] DRIFT_UP_STEPS_SLOW = 8'h0b;
  localparam logic [7:0] DRIFT_UP_STEPS_SYNC = 8'h37;
  localparam logic [7:0] DRIFT_DOWN_STEPS_SYNC = 8'h0a;
  localparam logic [7:0] SS_LFSR_SEED = 8'ha5;
  typedef enum logic [1:0] {
    TKS_ST_STRAP = 2'b00,
    TKS_ST_CAL = 2'b01,
    TKS_ST_RUN = 2'b10
  } tks_state_t;
endpackage : tks_pkg
`default_nettype wire

// [tks_top.sv]
// Four channel touch key signal processing top
`default_nettype none
// Notes on behaviour
// - Strap pin level at startup picks slow-sync or fast spread-spectrum mode.
// - Slow mode responds in about 100 ms and locks bursts to external sync.
// - Slow mode never drives spread-spectrum modulation.
// - Fast mode responds in about 40 ms, spreads spectrum, ignores sync.
// - One shared pin is sync input or spread-spectrum drive by mode.
// - Reset pin is active low; high allows normal operation.
// - Four channels each keep their own reference, detection and output.
// - All signal arithmetic is sixteen bits wide.
// - Reference tracks raw signal slowly, only when channel not detecting.
// - Threshold and hysteresis are relative to the current reference.
// - Detection freezes that channel's reference until detection ends.
// - Reference follows falling signal faster than rising signal.
// - Slow mode without sync paces drift from the 90 ms sleep interval.
// - With sync, drift counters advance once per sync period, limits scaled for 18 ms.
// - Detection threshold is twelve counts above reference on every channel.
// - Hysteresis of two counts below threshold before detection ends.
// - Key output needs six consecutive hits; a miss clears the counter.
// - Reset held low at least 10 us then released, and power-up, recalibrate every channel.
module tks_top
  import tks_pkg::*;
#(
  parameter int unsigned SLOW_ACQ = SLOW_ACQ_CYC,
  parameter int unsigned FAST_ACQ = FAST_ACQ_CYC
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Recalibration reset pin and strap
  input wire logic recal_reset_n_in,
  input wire logic strap_option_a_in,
  // Acquired signals, one 16-bit word per channel, with strobe
  input wire logic acq_valid_in,
  input wire logic [63:0] acq_raw_in,
  // Shared sync / spread-spectrum pin
  input wire logic sync_ss_in,
  output logic sync_ss_out,
  output logic sync_ss_oe_n_out,
  // Burst request to the acquisition front end, and fast mode flag
  output logic burst_req_out,
  output logic fast_mode_out,
  // Key outputs
  output logic key_output_1_out,
  output logic key_output_2_out,
  output logic key_output_3_out,
  output logic key_output_4_out
);
  initial begin
    if (SLOW_ACQ < 1 || FAST_ACQ < 1) begin
      $error("acquisition intervals must be at least one cycle");
    end
  end

  // Synchronisers for pins
  logic [1:0] rst_s_r, sync_s_r, strap_s_r, acqv_s_r;
  logic sync_prev_r;
  // Strap is read only once its synchroniser holds the pin level, not the reset fill
  logic [1:0] strap_wait_r;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_s_r <= 2'h0;
      sync_s_r <= 2'h0;
      strap_s_r <= 2'h0;
      acqv_s_r <= 2'h0;
      sync_prev_r <= 1'b0;
      strap_wait_r <= 2'h0;
    end else begin
      rst_s_r <= {rst_s_r[0], recal_reset_n_in};
      sync_s_r <= {sync_s_r[0], sync_ss_in};
      strap_s_r <= {strap_s_r[0], strap_option_a_in};
      acqv_s_r <= {acqv_s_r[0], acq_valid_in};
      sync_prev_r <= sync_s_r[1];
      strap_wait_r <= strap_wait_r[1] ? strap_wait_r : 2'(strap_wait_r + 2'h1);
    end
  end
  logic sync_rise;
  assign sync_rise = sync_s_r[1] & ~sync_prev_r;

  // Control state
  tks_state_t st_r, st_nxt;
  logic fast_r, fast_nxt;
  logic [31:0] tmr_r, tmr_nxt;
  logic [15:0] lowcnt_r, lowcnt_nxt;
  logic [7:0] up_r, up_nxt, dn_r, dn_nxt;
  logic [7:0] lfsr_r, lfsr_nxt;
  logic sync_seen_r, sync_seen_nxt;
  logic burst_r, burst_nxt;
  logic cal_pend_r, cal_pend_nxt;
  // Some channel hit on the last acquisition and is still integrating
  logic pend_r, pend_nxt;
  logic cal, acq_stb, up_stb, dn_stb, any_integ;
  logic [3:0] det;
  logic [7:0] up_lim, dn_lim;

  always_comb begin
    st_nxt = st_r;
    fast_nxt = fast_r;
    tmr_nxt = 32'(tmr_r + 32'h1);
    lowcnt_nxt = rst_s_r[1] ? 16'h0000 : 16'(lowcnt_r + ((lowcnt_r == 16'hffff) ? 16'h0 : 16'h1));
    up_nxt = up_r;
    dn_nxt = dn_r;
    lfsr_nxt = lfsr_r;
    sync_seen_nxt = sync_seen_r;
    burst_nxt = 1'b0;
    cal_pend_nxt = cal_pend_r;
    pend_nxt = pend_r;
    cal = 1'b0;
    up_stb = 1'b0;
    dn_stb = 1'b0;
    acq_stb = 1'b0;
    // Held low long enough, then released: recalibrate on release
    if (rst_s_r[1] && lowcnt_r >= 16'(RESET_MIN_CYC)) begin
      cal_pend_nxt = 1'b1;
    end
    up_lim = sync_seen_r ? DRIFT_UP_STEPS_SYNC : DRIFT_UP_STEPS_SLOW;
    dn_lim = sync_seen_r ? DRIFT_DOWN_STEPS_SYNC : DRIFT_DOWN_STEPS;
    case (st_r)
      TKS_ST_STRAP: begin
        if (strap_wait_r[1]) begin
          fast_nxt = ~strap_s_r[1];
          st_nxt = TKS_ST_CAL;
        end
      end
      TKS_ST_CAL: begin
        burst_nxt = 1'b1;
        if (acqv_s_r[1]) begin
          cal = 1'b1;
          cal_pend_nxt = 1'b0;
          tmr_nxt = 32'h0;
          st_nxt = TKS_ST_RUN;
        end
      end
      TKS_ST_RUN: begin
        if (cal_pend_r) begin
          st_nxt = TKS_ST_CAL;
        end
        if (fast_r) begin
          // Pseudo-random jitter on burst timing
          if (tmr_r >= 32'(FAST_ACQ) + {24'h0, lfsr_r[7:6], 6'h00}) begin
            burst_nxt = 1'b1;
            tmr_nxt = 32'h0;
            lfsr_nxt = {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
          end
        end else if (sync_rise) begin
          burst_nxt = 1'b1;
          sync_seen_nxt = 1'b1;
          tmr_nxt = 32'h0;
        end else if (any_integ && tmr_r >= 32'(FAST_ACQ)) begin
          burst_nxt = 1'b1; // Confirming a touch runs without sleep
          tmr_nxt = 32'h0;
        end else if (tmr_r >= 32'(SLOW_ACQ)) begin
          burst_nxt = 1'b1;
          sync_seen_nxt = 1'b0;
          tmr_nxt = 32'h0;
        end
        if (acqv_s_r[1] && !burst_r) begin
          acq_stb = 1'b1;
          // Drift pacing per acquisition, limits picked by sync seen; fast mode uses the sleep limits
          up_nxt = (up_r >= up_lim) ? 8'h00 : 8'(up_r + 8'h01);
          dn_nxt = (dn_r >= dn_lim) ? 8'h00 : 8'(dn_r + 8'h01);
          up_stb = up_r >= up_lim;
          dn_stb = dn_r >= dn_lim;
        end
      end
      default: begin
        st_nxt = TKS_ST_STRAP;
      end
    endcase
    // Raw words are only valid at an acquisition, so the hit is latched there
    if (acq_stb) begin
      pend_nxt = |integ_any;
    end
    if (cal) begin
      pend_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_r <= TKS_ST_STRAP;
      fast_r <= 1'b0;
      tmr_r <= 32'h0;
      lowcnt_r <= 16'h0;
      up_r <= 8'h00;
      dn_r <= 8'h00;
      lfsr_r <= SS_LFSR_SEED;
      sync_seen_r <= 1'b0;
      burst_r <= 1'b0;
      cal_pend_r <= 1'b0;
      pend_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      fast_r <= fast_nxt;
      tmr_r <= tmr_nxt;
      lowcnt_r <= lowcnt_nxt;
      up_r <= up_nxt;
      dn_r <= dn_nxt;
      lfsr_r <= lfsr_nxt;
      sync_seen_r <= sync_seen_nxt;
      burst_r <= burst_nxt;
      cal_pend_r <= cal_pend_nxt;
      pend_r <= pend_nxt;
    end
  end

  // Shared pin: drive spread-spectrum only in fast mode, else input
  logic ss_r;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ss_r <= 1'b0;
    end else begin
      ss_r <= lfsr_r[0];
    end
  end
  assign sync_ss_out = fast_r ? ss_r : 1'b0;
  assign sync_ss_oe_n_out = ~(fast_r && st_r == TKS_ST_RUN);
  assign burst_req_out = burst_r;
  assign fast_mode_out = fast_r;

  // Channels
  logic [3:0] integ_any;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_ch
      tks_ch_if chl ();
      assign chl.acq_stb = acq_stb;
      assign chl.cal = cal;
      assign chl.drift_up_stb = up_stb;
      assign chl.drift_dn_stb = dn_stb;
      assign chl.raw = acq_raw_in[g*16 +: 16];
      assign det[g] = chl.detect;
      assign integ_any[g] = chl.raw >= 16'(chl.reference + THRESH_CNT) && !chl.detect;
      tks_channel u_ch (
        .clk_in(clk_in),
        .nrst_in(nrst_in),
        .chl(chl)
      );
    end
  endgenerate
  assign any_integ = pend_r;

  assign key_output_1_out = det[0];
  assign key_output_2_out = det[1];
  assign key_output_3_out = det[2];
  assign key_output_4_out = det[3];
endmodule : tks_top
`default_nettype wire

// [tks_top_monitor.sv]
// Port checker for the touch key top
`default_nettype none
module tks_top_monitor
  import tks_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Inputs
  input wire logic recal_reset_n_in,
  input wire logic strap_option_a_in,
  input wire logic acq_valid_in,
  input wire logic [63:0] acq_raw_in,
  input wire logic sync_ss_in,
  // Outputs
  input wire logic sync_ss_out,
  input wire logic sync_ss_oe_n_out,
  input wire logic burst_req_out,
  input wire logic fast_mode_out,
  input wire logic key_output_1_out,
  input wire logic key_output_2_out,
  input wire logic key_output_3_out,
  input wire logic key_output_4_out
);
  logic [3:0] keys;
  logic [3:0] n_acq_r;
  logic [3:0] n_acq_nxt;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  assign keys = {key_output_4_out, key_output_3_out, key_output_2_out, key_output_1_out};
  // Acquisitions seen since reset, saturating
  always_comb n_acq_nxt = (acq_valid_in && n_acq_r != 4'hf) ? n_acq_r + 4'h1 : n_acq_r;
  always_ff @(posedge clk_in or negedge nrst_in)
    if (!nrst_in) n_acq_r <= 4'h0;
    else n_acq_r <= n_acq_nxt;
  ss_slow_a: assert property (!fast_mode_out |-> !sync_ss_out)
    else $error("spread drive in slow mode");
  oe_slow_a: assert property (!fast_mode_out |-> sync_ss_oe_n_out)
    else $error("shared pin driven in slow mode");
  mode_strap_a: assert property (fast_mode_out |-> !strap_option_a_in)
    else $error("fast mode with slow strap");
  key1_rise_a: assert property ($rose(key_output_1_out) |-> $past(acq_valid_in, 3))
    else $error("key 1 rose without acquisition");
  key2_rise_a: assert property ($rose(key_output_2_out) |-> $past(acq_valid_in, 3))
    else $error("key 2 rose without acquisition");
  key4_rise_a: assert property ($rose(key_output_4_out) |-> $past(acq_valid_in, 3))
    else $error("key 4 rose without acquisition");
  key_fall_a: assert property ((($past(keys) & ~keys) != 4'h0) |-> $past(acq_valid_in, 3))
    else $error("key fell without acquisition");
  key_count_a: assert property ((keys != 4'h0) |-> (n_acq_r >= 4'h7))
    else $error("key high after too few acquisitions");
  cover property ($rose(key_output_1_out));
  cover property ($fell(key_output_1_out));
  cover property (!sync_ss_oe_n_out);
endmodule : tks_top_monitor
bind tks_top tks_top_monitor mon (.clk_in(clk_in), .nrst_in(nrst_in),
  .recal_reset_n_in(recal_reset_n_in), .strap_option_a_in(strap_option_a_in),
  .acq_valid_in(acq_valid_in), .acq_raw_in(acq_raw_in), .sync_ss_in(sync_ss_in),
  .sync_ss_out(sync_ss_out), .sync_ss_oe_n_out(sync_ss_oe_n_out),
  .burst_req_out(burst_req_out), .fast_mode_out(fast_mode_out),
  .key_output_1_out(key_output_1_out), .key_output_2_out(key_output_2_out),
  .key_output_3_out(key_output_3_out), .key_output_4_out(key_output_4_out));
`default_nettype wire
